// *** rhda_consts.svh ***
// register map, field positions, reset values and timing constants of the root hub descriptor
`ifndef RHDA_CONSTS_SVH
`define RHDA_CONSTS_SVH

`define RHDA_REG_OFFSET   8'h48
`define RHDA_PGD_MSB      31
`define RHDA_PGD_LSB      24
`define RHDA_RSVD_MSB     23
`define RHDA_RSVD_LSB     13
`define RHDA_NOOC_BIT       12
`define RHDA_OCMODE_BIT     11
`define RHDA_COMPOUND_BIT   10
`define RHDA_NOSW_BIT       9
`define RHDA_SWMODE_BIT     8
`define RHDA_PORTS_MSB      7
`define RHDA_PORTS_LSB      0

`define RHDA_PGD_RST        8'hFF
`define RHDA_NOOC_RST       1'b0
`define RHDA_NOSW_RST       1'b0
`define RHDA_SWMODE_RST     1'b1
`define RHDA_PORTS_RST      8'h02
`define RHDA_COMPOUND_VALUE 1'b0

`define RHDA_MIN_PORTS    8'h01
`define RHDA_MAX_PORTS    15

`define RHDA_UNIT_NS      2000000
`define RHDA_CLK_NS       20
`define RHDA_UNIT_CYCLES  (`RHDA_UNIT_NS / `RHDA_CLK_NS)

`endif

// *** rhda_pkg.sv ***
// types and shared decoding for the root hub descriptor block
`include "rhda_consts.svh"

package rhda_pkg;

   typedef enum logic [1:0] {
      RHDA_PM_GANGED     = 2'b00,
      RHDA_PM_INDIVIDUAL = 2'b01,
      RHDA_PM_ALWAYS     = 2'b11
   } rhda_power_mode_t;

   typedef enum logic [1:0] {
      RHDA_OC_COLLECTIVE = 2'b00,
      RHDA_OC_PER_PORT   = 2'b01,
      RHDA_OC_NONE       = 2'b11
   } rhda_oc_mode_t;

   typedef struct packed {
      logic [7:0]                    power_good_delay;
      logic                          no_overcurrent_protection;
      logic                          overcurrent_report_mode;
      logic                          no_power_switching;
      logic                          power_switch_mode;
      logic [31:0]                   rdata;
      logic                          rd_valid;
      logic [23:0]                   tick_cnt;
      logic                          tick;
      logic                          oc_global;
      logic [`RHDA_MAX_PORTS-1:0]    oc_port;
   } rhda_top_state_t;

   typedef struct packed {
      logic [`RHDA_MAX_PORTS-1:0]        power;
      logic [`RHDA_MAX_PORTS-1:0]        good;
      logic [`RHDA_MAX_PORTS-1:0][7:0]   wait_cnt;
   } rhda_port_state_t;

   // switching scheme from the two descriptor bits
   function automatic rhda_power_mode_t rhda_power_mode(input logic no_sw, input logic sw_mode);
      if (no_sw) begin
         return RHDA_PM_ALWAYS;
      end
      return sw_mode ? RHDA_PM_INDIVIDUAL : RHDA_PM_GANGED;
   endfunction

   // reporting scheme from the two descriptor bits
   function automatic rhda_oc_mode_t rhda_oc_mode(input logic no_oc, input logic oc_rep);
      if (no_oc) begin
         return RHDA_OC_NONE;
      end
      return oc_rep ? RHDA_OC_PER_PORT : RHDA_OC_COLLECTIVE;
   endfunction

endpackage

// *** rhda_port_power.sv ***
// per-port power switching and power-on-to-power-good timing of the root hub
`include "rhda_consts.svh"
module rhda_port_power
   import rhda_pkg::*;
#(
   parameter int NUM_PORTS = 2
) (
   input  wire logic                         i_clk,             // system clock
   input  wire logic                         i_rstn,            // synchronous reset, active low
   input  wire logic                         i_no_sw,           // no power switching
   input  wire logic                         i_sw_mode,         // power switch mode
   input  wire logic [7:0]                   i_pgd,             // power good delay in 2 ms units
   input  wire logic                         i_tick,            // one pulse per 2 ms
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_mask,            // per_port_power_mask, bit n = port n+1
   input  wire logic                         i_global_set,      // set global power
   input  wire logic                         i_global_clr,      // clear global power
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_port_set,        // set port power
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_port_clr,        // clear port power
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_oc_off,          // overcurrent power removal
   output logic      [`RHDA_MAX_PORTS-1:0]   o_power,           // port power state
   output logic      [`RHDA_MAX_PORTS-1:0]   o_good             // power good reached
);

   rhda_port_state_t  st_ff;
   rhda_port_state_t  nxt_st;
   rhda_power_mode_t  mode;

   assign mode = rhda_power_mode(i_no_sw, i_sw_mode);

   always_comb begin
      logic on_cmd;
      logic off_cmd;
      on_cmd  = 1'b0;
      off_cmd = 1'b0;
      nxt_st  = st_ff;
      for (int p = 0; p < `RHDA_MAX_PORTS; p++) begin
         case (mode)
            RHDA_PM_ALWAYS: begin
               on_cmd  = 1'b1;
               off_cmd = 1'b0;
            end
            RHDA_PM_INDIVIDUAL: begin
               if (i_mask[p]) begin
                  on_cmd  = i_port_set[p];                                  // [R10]
                  off_cmd = i_port_clr[p];                                  // [R10]
               end else begin
                  on_cmd  = i_global_set;                                   // [R11]
                  off_cmd = i_global_clr;                                   // [R11]
               end
            end
            default: begin
               on_cmd  = i_global_set;                                      // [R9]
               off_cmd = i_global_clr;                                      // [R9]
            end
         endcase
         if (p >= NUM_PORTS) begin
            nxt_st.power[p] = 1'b0;
         end else if ((off_cmd || i_oc_off[p]) && mode != RHDA_PM_ALWAYS) begin
            nxt_st.power[p] = 1'b0;
         end else if (on_cmd) begin
            nxt_st.power[p] = 1'b1;                                         // [R8]
         end
         // restart the wait whenever a port newly turns on
         if (nxt_st.power[p] && !st_ff.power[p]) begin
            nxt_st.wait_cnt[p] = i_pgd;                                     // [R2]
         end else if (i_tick && st_ff.wait_cnt[p] != 8'h00) begin
            nxt_st.wait_cnt[p] = st_ff.wait_cnt[p] - 8'h01;                 // [R2]
         end
         nxt_st.good[p] = nxt_st.power[p] && nxt_st.wait_cnt[p] == 8'h00;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_power = st_ff.power;
   assign o_good  = st_ff.good;

endmodule

// *** rhda_top.sv ***
// root hub descriptor A register with the port power and overcurrent logic it configures
//
// Functional notes
// [R1] software rewrites reserved bits with reset value
// [R2] bits 31:24 power good delay, 2 ms units
// [R3] software waits that delay before port access
// [R4] bit 12: collective overcurrent or none
// [R5] bit 11: collective/per-port when bit 12 clear
// [R6] reset overcurrent mode equals power switch mode
// [R7] bit 10 compound device always reads 0
// [R8] bit 9: switched or always powered ports
// [R9] bit 8: ganged or individual when bit 9 clear
// [R10] masked port obeys only per-port commands
// [R11] unmasked port obeys only global commands
// [R12] bits 7:0 port count, 1 to 15
// [R13] reserved bits read zero, writes ignored
`include "rhda_consts.svh"
module rhda_top
   import rhda_pkg::*;
#(
   parameter logic [7:0]  PGD_RESET     = `RHDA_PGD_RST,      // power good delay after reset
   parameter logic        NO_OC_RESET   = `RHDA_NOOC_RST,     // no overcurrent protection after reset
   parameter logic        NO_SW_RESET   = `RHDA_NOSW_RST,     // no power switching after reset
   parameter logic        SW_MODE_RESET = `RHDA_SWMODE_RST,   // power switch mode after reset
   parameter logic [7:0]  PORTS_BUILT   = `RHDA_PORTS_RST,    // downstream ports built in
   parameter logic [23:0] UNIT_CYCLES   = 24'(`RHDA_UNIT_CYCLES) // clock cycles per 2 ms
) (
   input  wire logic                         i_clk,             // system clock, 50 MHz
   input  wire logic                         i_rstn,            // synchronous reset, active low
   input  wire logic [7:0]                   i_addr,            // register byte offset
   input  wire logic                         i_wr_en,           // write strobe
   input  wire logic                         i_rd_en,           // read strobe
   input  wire logic [3:0]                   i_be,              // byte enables
   input  wire logic [31:0]                  i_wdata,           // write data
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_per_port_power_mask, // mask, bit n = port n+1
   input  wire logic                         i_global_set,      // set global power command
   input  wire logic                         i_global_clr,      // clear global power command
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_port_set,        // set port power commands
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_port_clr,        // clear port power commands
   input  wire logic [`RHDA_MAX_PORTS-1:0]   i_overcurrent,     // overcurrent sense per port
   output logic      [31:0]                  o_rdata,           // read data
   output logic                              o_rd_valid,        // read data valid pulse
   output logic      [`RHDA_MAX_PORTS-1:0]   o_port_power,      // port power state
   output logic      [`RHDA_MAX_PORTS-1:0]   o_port_power_good, // power good delay elapsed
   output logic                              o_oc_global,       // collective overcurrent
   output logic      [`RHDA_MAX_PORTS-1:0]   o_oc_port          // per-port overcurrent
);

   ////////////////////////////////////////////////////////////////////////////////

   // reported port count, held inside 1..15
   function automatic logic [7:0] port_count(input logic [7:0] n);
      if (n < `RHDA_MIN_PORTS) begin
         return `RHDA_MIN_PORTS;
      end
      if (n > 8'(`RHDA_MAX_PORTS)) begin
         return 8'(`RHDA_MAX_PORTS);
      end
      return n;
   endfunction

   function automatic logic reg_hit(input logic [7:0] addr);
      return addr == `RHDA_REG_OFFSET;
   endfunction

   localparam logic [7:0] PORT_COUNT = port_count(PORTS_BUILT);             // [R12]
   localparam int         NUM_PORTS  = int'(PORT_COUNT);

   ////////////////////////////////////////////////////////////////////////////////

   rhda_top_state_t             st_ff;
   rhda_top_state_t             nxt_st;
   rhda_oc_mode_t               oc_mode;
   rhda_power_mode_t            pw_mode;
   logic [`RHDA_MAX_PORTS-1:0]  port_valid;
   logic [`RHDA_MAX_PORTS-1:0]  oc_seen;
   logic [`RHDA_MAX_PORTS-1:0]  oc_off;
   logic [31:0]                 reg_value;

   assign oc_mode = rhda_oc_mode(st_ff.no_overcurrent_protection, st_ff.overcurrent_report_mode);
   assign pw_mode = rhda_power_mode(st_ff.no_power_switching, st_ff.power_switch_mode);

   generate
      for (genvar p = 0; p < `RHDA_MAX_PORTS; p++) begin : g_valid
         assign port_valid[p] = (p < NUM_PORTS);
      end
   endgenerate

   assign oc_seen = i_overcurrent & port_valid;

   // overcurrent removes power from switched ports the way it is reported
   always_comb begin
      case (oc_mode)
         RHDA_OC_COLLECTIVE: oc_off = (|oc_seen) ? port_valid : '0;         // [R4]
         RHDA_OC_PER_PORT:   oc_off = oc_seen;                              // [R5]
         default:            oc_off = '0;                                   // [R4]
      endcase
   end

   always_comb begin
      reg_value = '0;                                                       // [R13]
      reg_value[`RHDA_PGD_MSB:`RHDA_PGD_LSB] = st_ff.power_good_delay;      // [R2]
      reg_value[`RHDA_NOOC_BIT]     = st_ff.no_overcurrent_protection;      // [R4]
      reg_value[`RHDA_OCMODE_BIT]   = st_ff.overcurrent_report_mode;        // [R5]
      reg_value[`RHDA_COMPOUND_BIT] = `RHDA_COMPOUND_VALUE;                 // [R7]
      reg_value[`RHDA_NOSW_BIT]     = st_ff.no_power_switching;             // [R8]
      reg_value[`RHDA_SWMODE_BIT]   = st_ff.power_switch_mode;              // [R9]
      reg_value[`RHDA_PORTS_MSB:`RHDA_PORTS_LSB] = PORT_COUNT;              // [R12]
   end

   ////////////////////////////////////////////////////////////////////////////////

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.rd_valid = 1'b0;
      nxt_st.tick     = 1'b0;
      // 2 ms enable for the power good timers
      if (st_ff.tick_cnt >= UNIT_CYCLES - 24'h000001) begin
         nxt_st.tick_cnt = '0;
         nxt_st.tick     = 1'b1;                                            // [R2]
      end else begin
         nxt_st.tick_cnt = st_ff.tick_cnt + 24'h000001;
      end
      if (i_wr_en && reg_hit(i_addr)) begin
         // reserved, device type and port count bits are not writable
         if (i_be[3]) begin
            nxt_st.power_good_delay = i_wdata[`RHDA_PGD_MSB:`RHDA_PGD_LSB]; // [R2]
         end
         if (i_be[1]) begin
            nxt_st.no_overcurrent_protection = i_wdata[`RHDA_NOOC_BIT];     // [R4]
            nxt_st.overcurrent_report_mode   = i_wdata[`RHDA_OCMODE_BIT];   // [R5]
            nxt_st.no_power_switching        = i_wdata[`RHDA_NOSW_BIT];     // [R8]
            nxt_st.power_switch_mode         = i_wdata[`RHDA_SWMODE_BIT];   // [R9]
         end
      end
      if (i_rd_en) begin
         nxt_st.rd_valid = 1'b1;
         nxt_st.rdata    = reg_hit(i_addr) ? reg_value : 32'h00000000;
      end
      nxt_st.oc_global = (oc_mode == RHDA_OC_COLLECTIVE) && (|oc_seen);     // [R4]
      nxt_st.oc_port   = (oc_mode == RHDA_OC_PER_PORT) ? oc_seen : '0;      // [R5]
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         st_ff                           <= '0;
         st_ff.power_good_delay          <= PGD_RESET;
         st_ff.no_overcurrent_protection <= NO_OC_RESET;
         st_ff.overcurrent_report_mode   <= SW_MODE_RESET;                  // [R6]
         st_ff.no_power_switching        <= NO_SW_RESET;
         st_ff.power_switch_mode         <= SW_MODE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   rhda_port_power #(
      .NUM_PORTS (NUM_PORTS)
   ) u_port_power (
      .i_clk        (i_clk),
      .i_rstn       (i_rstn),
      .i_no_sw      (st_ff.no_power_switching),
      .i_sw_mode    (st_ff.power_switch_mode),
      .i_pgd        (st_ff.power_good_delay),
      .i_tick       (st_ff.tick),
      .i_mask       (i_per_port_power_mask),
      .i_global_set (i_global_set),
      .i_global_clr (i_global_clr),
      .i_port_set   (i_port_set),
      .i_port_clr   (i_port_clr),
      .i_oc_off     (oc_off),
      .o_power      (o_port_power),
      .o_good       (o_port_power_good)
   );

   assign o_rdata     = st_ff.rdata;
   assign o_rd_valid  = st_ff.rd_valid;
   assign o_oc_global = st_ff.oc_global;
   assign o_oc_port   = st_ff.oc_port;

endmodule

// *** rhda_top_props.sv ***
// concurrent checks on the ports of the root hub descriptor block
`include "rhda_consts.svh"
module rhda_top_props
   import rhda_pkg::*;
#(
   parameter logic [7:0] PORTS_BUILT = `RHDA_PORTS_RST // downstream ports built in
) (
   input wire logic                       i_clk,             // system clock
   input wire logic                       i_rstn,            // synchronous reset, active low
   input wire logic [7:0]                 i_addr,            // register byte offset
   input wire logic                       i_wr_en,           // write strobe
   input wire logic                       i_rd_en,           // read strobe
   input wire logic [3:0]                 i_be,              // byte enables
   input wire logic [31:0]                i_wdata,           // write data
   input wire logic [`RHDA_MAX_PORTS-1:0] i_overcurrent,     // overcurrent sense
   input wire logic [31:0]                o_rdata,           // read data
   input wire logic                       o_rd_valid,        // read data valid
   input wire logic [`RHDA_MAX_PORTS-1:0] o_port_power,      // port power state
   input wire logic [`RHDA_MAX_PORTS-1:0] o_port_power_good, // power good reached
   input wire logic                       o_oc_global,       // collective overcurrent
   input wire logic [`RHDA_MAX_PORTS-1:0] o_oc_port          // per-port overcurrent
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////////////////////////////////////////////
   a_read_answer: assert property (i_rd_en |=> o_rd_valid) else $error("read not answered");
   a_valid_pulse: assert property (!i_rd_en |=> !o_rd_valid) else $error("valid without read");
   a_fixed_fields: assert property (i_rd_en && i_addr == 8'h48 |=>
      o_rdata[23:13] == 11'h000 && !o_rdata[10] && o_rdata[7:0] == PORTS_BUILT) else $error("fixed field wrong");
   a_unmapped_zero: assert property (i_rd_en && i_addr != 8'h48 |=> o_rdata == 32'h0) else $error("unmapped not 0");
   a_write_visible: assert property ((i_wr_en && i_addr == 8'h48 && i_be[3] && !i_rd_en) ##1 !i_wr_en ##1
      (i_rd_en && i_addr == 8'h48 && !i_wr_en) |=> o_rdata[31:24] == $past(i_wdata[31:24], 3))
      else $error("delay field not written");
   a_ports_limited: assert property ((32'(o_port_power) >> PORTS_BUILT) == 32'h0)
      else $error("port above count");
   a_good_powered: assert property ((o_port_power_good & ~o_port_power) == 15'h0)
      else $error("good unpowered");
   a_oc_exclusive: assert property (!(o_oc_global && (|o_oc_port)))
      else $error("both oc schemes");
   a_oc_global_cause: assert property (o_oc_global |-> $past(|i_overcurrent))
      else $error("oc without cause");
   a_oc_port_cause: assert property ((o_oc_port & ~$past(i_overcurrent)) == 15'h0)
      else $error("port oc no cause");
   c_read: cover property (o_rd_valid);
   c_good: cover property (o_port_power_good != 15'h0);
   c_oc_global: cover property (o_oc_global);
   c_oc_port: cover property (|o_oc_port);
endmodule

// *** test_rhda_top.sv ***
// self-checking bench for the root hub descriptor block
`include "rhda_consts.svh"
module test_rhda_top
   import rhda_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk = 1'b0;
   logic        i_rstn = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic        i_wr_en = 1'b0;
   logic        i_rd_en = 1'b0;
   logic [3:0]  i_be = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic [14:0] i_mask = 15'h0;
   logic        i_gs = 1'b0;
   logic        i_gc = 1'b0;
   logic [14:0] i_ps = 15'h0;
   logic [14:0] i_pc = 15'h0;
   logic [14:0] i_oc = 15'h0;
   logic [31:0] o_rdata;
   logic        o_rd_valid;
   logic [14:0] o_pwr;
   logic [14:0] o_good;
   logic        o_ocg;
   logic [14:0] o_ocp;
   int          errors = 0;
   int          n_checks = 0;
   int          cycles = 0;
   always #10 i_clk = ~i_clk;
   rhda_top #(.UNIT_CYCLES(24'h4)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wr_en(i_wr_en),
      .i_rd_en(i_rd_en), .i_be(i_be), .i_wdata(i_wdata), .i_per_port_power_mask(i_mask), .i_global_set(i_gs),
      .i_global_clr(i_gc), .i_port_set(i_ps), .i_port_clr(i_pc), .i_overcurrent(i_oc), .o_rdata(o_rdata),
      .o_rd_valid(o_rd_valid), .o_port_power(o_pwr), .o_port_power_good(o_good), .o_oc_global(o_ocg),
      .o_oc_port(o_ocp));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      i_addr = a;
      i_be = be;
      i_wdata = d;
      i_wr_en = 1'b1;
      @(negedge i_clk);
      i_wr_en = 1'b0;
      @(negedge i_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_addr = a;
      i_rd_en = 1'b1;
      @(negedge i_clk);
      i_rd_en = 1'b0;
      chk("rd_valid", 32'h1, 32'(o_rd_valid));
      chk("rdata", exp, o_rdata);
      @(negedge i_clk);
   endtask
   task automatic cmd(input logic gs, input logic gc, input logic [14:0] ps, input logic [14:0] pc,
                      input logic [14:0] exp);
      i_gs = gs;
      i_gc = gc;
      i_ps = ps;
      i_pc = pc;
      @(negedge i_clk);
      {i_gs, i_gc, i_ps, i_pc} = '0;
      chk("port_power", 32'(exp), 32'(o_pwr));
      @(negedge i_clk);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (12) @(negedge i_clk);
      i_rstn = 1'b1;
      rd(8'h48, 32'hFF000902);
      rd(8'h4C, 32'h0);
      wr(8'h48, 4'hF, 32'hFF001FFF);
      rd(8'h48, 32'hFF001B02);
      wr(8'h4C, 4'hF, 32'h0);
      wr(8'h48, 4'h0, 32'h0);
      rd(8'h48, 32'hFF001B02);
      wr(8'h48, 4'hF, 32'h02000000);
      rd(8'h48, 32'h02000002);
      cmd(1'b0, 1'b1, 15'h0, 15'h0, 15'h0);
      cmd(1'b0, 1'b0, 15'h3, 15'h0, 15'h0);
      cmd(1'b1, 1'b0, 15'h0, 15'h0, 15'h3);
      chk("power_good", 32'h0, 32'(o_good));
      wait_n(3);
      chk("power_good", 32'h0, 32'(o_good));
      wait_n(2);
      chk("power_good", 32'h3, 32'(o_good));
      i_oc = 15'h1;
      wait_n(1);
      chk("oc_global", 32'h1, 32'(o_ocg));
      wait_n(1);
      chk("port_power", 32'h0, 32'(o_pwr));
      i_oc = 15'h0;
      wait_n(2);
      chk("oc_global", 32'h0, 32'(o_ocg));
      wr(8'h48, 4'hF, 32'h02000900);
      i_mask = 15'h1;
      cmd(1'b1, 1'b0, 15'h0, 15'h0, 15'h2);
      cmd(1'b0, 1'b0, 15'h3, 15'h0, 15'h3);
      cmd(1'b0, 1'b0, 15'h0, 15'h2, 15'h3);
      cmd(1'b0, 1'b1, 15'h0, 15'h0, 15'h1);
      cmd(1'b0, 1'b0, 15'h0, 15'h1, 15'h0);
      i_mask = 15'h7FFF;
      cmd(1'b0, 1'b0, 15'h7FFF, 15'h0, 15'h3);
      i_oc = 15'h2;
      wait_n(1);
      chk("oc_port", 32'h2, 32'(o_ocp));
      chk("oc_global", 32'h0, 32'(o_ocg));
      wait_n(1);
      chk("port_power", 32'h1, 32'(o_pwr));
      i_oc = 15'h0;
      wr(8'h48, 4'hF, 32'h02001000);
      i_oc = 15'h3;
      wait_n(2);
      chk("oc_port", 32'h0, 32'(o_ocp));
      chk("oc_global", 32'h0, 32'(o_ocg));
      chk("port_power", 32'h1, 32'(o_pwr));
      i_oc = 15'h0;
      wr(8'h48, 4'hF, 32'h02000200);
      wait_n(2);
      chk("port_power", 32'h3, 32'(o_pwr));
      cmd(1'b0, 1'b1, 15'h0, 15'h3, 15'h3);
      end_of_test();
   end
endmodule
bind rhda_top rhda_top_props #(.PORTS_BUILT(PORTS_BUILT)) u_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
   .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_be(i_be), .i_wdata(i_wdata), .i_overcurrent(i_overcurrent),
   .o_rdata(o_rdata), .o_rd_valid(o_rd_valid), .o_port_power(o_port_power),
   .o_port_power_good(o_port_power_good), .o_oc_global(o_oc_global), .o_oc_port(o_oc_port));
